// ==== design/line_ctl.sv ====
// RS-485 driver enable, echo suppression and baud prescale control
`timescale 1ns/100ps
`include "line_ctl_defs.svh"

// Contract
// - Only one bus driver enabled at once
// - RTS setting: driver enable follows UART RTS
// - Auto setting: hardware drives enable itself
// - Echo allowed: sent characters are received
// - No-echo: receiver off while transmitting
// - Baud clock through divide-by-4 or 1 prescaler
// - Divide-by-4 keeps usual PC rates, 115.2K
// - Divide-by-1 bypasses prescaler, up to 460.8K
// - Divide-by-1 line rate four times programmed
// - Loopback ties TX+ to RX+, TX- to RX-
module line_ctl (
    // Clock and reset
    input  wire logic   ref_clk,
    input  wire logic   rst,
    // Switch settings from the mode switch bank
    input  wire logic   auto_driver_enable_setting,
    input  wire logic   rts_driven_enable_setting,
    input  wire logic   receive_suppress_setting,
    input  wire logic   prescale_bypass_setting,
    input  wire logic   prescale_quarter_setting,
    // Loopback settings from the line switch bank
    input  wire logic   loop_pos_setting,
    input  wire logic   loop_neg_setting,
    // UART side
    input  wire logic   uart_txd,
    input  wire logic   uart_rts,
    output logic        uart_rxd,
    output logic        uart_baud_tick,
    // Line side, differential pairs
    output logic        tx_pos,
    output logic        tx_neg,
    output logic        tx_drv_en,
    input  wire logic   rx_pos,
    input  wire logic   rx_neg,
    output logic        rx_en,
    // Status
    output logic        clk_sel_bad,
    output logic        line_busy
);
    import line_ctl_pkg::*;

    // ************************************************************
    // Input synchronisers
    // ************************************************************
    logic [`SYNC_W-1:0] sync1_reg;
    logic [`SYNC_W-1:0] sync2_reg;
    logic               s_auto;
    logic               s_rts_mode;
    logic               s_no_echo;
    logic               s_bypass;
    logic               s_quarter;
    logic               s_loop_pos;
    logic               s_loop_neg;
    logic               s_txd;
    logic               s_rts;
    logic               s_rx_pos;
    logic               s_rx_neg;

    // Switches and pins are asynchronous, two flops each; reset
    // loads idle levels so the receive pair reads as a mark and
    // no false start bit reaches the UART after reset
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            sync1_reg <= `SYNC_RESET;
            sync2_reg <= `SYNC_RESET;
        end else begin
            sync1_reg <= {auto_driver_enable_setting,
                          rts_driven_enable_setting,
                          receive_suppress_setting,
                          prescale_bypass_setting,
                          prescale_quarter_setting,
                          loop_pos_setting, loop_neg_setting,
                          uart_txd, uart_rts, rx_pos, rx_neg};
            sync2_reg <= sync1_reg;
        end
    end

    // Synchronised names
    assign {s_auto, s_rts_mode, s_no_echo, s_bypass, s_quarter,
            s_loop_pos, s_loop_neg,
            s_txd, s_rts, s_rx_pos, s_rx_neg} = sync2_reg;

    // ************************************************************
    // Mode decode
    // ************************************************************
    drv_src_t   drv_src;
    clk_sel_t   clk_sel;

    // Both enable sources at once is treated as no driver
    assign drv_src = (s_auto && s_rts_mode) ? DRV_BAD :
                     s_auto     ? DRV_AUTO :
                     s_rts_mode ? DRV_RTS  : DRV_OFF;

    // Both prescale settings flag invalid; tick is then stopped
    assign clk_sel = (s_bypass && s_quarter) ? CLK_INVALID :
                     s_bypass  ? CLK_BYPASS  :
                     s_quarter ? CLK_QUARTER : CLK_NONE;

    // ************************************************************
    // Baud prescaler
    // ************************************************************
    baud_tick_if bt ();

    baud_prescaler u_pre (
        .ref_clk (ref_clk),
        .rst     (rst),
        .sel     (clk_sel),
        .bt      (bt.source)
    );

    // Bypass gives the UART four times the ticks, so the line
    // runs at four times the programmed rate; divisor mapping
    // for software follows from that alone
    assign uart_baud_tick = bt.tick;
    assign clk_sel_bad    = !bt.sel_ok;

    // ************************************************************
    // Automatic enable: frame tracker on the transmit data
    // ************************************************************
    typedef enum logic [1:0] {
        AT_IDLE,
        AT_BITS,
        AT_STOP
    } at_state_t;

    at_state_t                  at_reg;
    at_state_t                  at_next;
    logic [`TICK_CNT_W-1:0]     tick_reg;
    logic [`TICK_CNT_W-1:0]     tick_next;
    logic [`BIT_CNT_W-1:0]      bit_reg;
    logic [`BIT_CNT_W-1:0]      bit_next;
    logic                       bit_end;
    logic                       frame_end;
    logic                       guard_end;

    // Tick counter step, shared by both counting states
    function automatic logic [`TICK_CNT_W-1:0] tick_step(
        input logic [`TICK_CNT_W-1:0] cnt,
        input logic                   tick,
        input logic                   wrap
    );
        if (!tick) begin
            return cnt;
        end
        return wrap ? '0 : cnt + 1'b1;
    endfunction

    // A bit lasts sixteen baud ticks of the UART
    assign bit_end   = bt.tick && (tick_reg == `TICK_LAST);
    assign frame_end = bit_end && (bit_reg == `FRAME_LAST_BIT);
    assign guard_end = bt.tick && (tick_reg == `HALF_BIT_TICK);

    // Start on a falling data edge and count a whole frame, so
    // high data bits never release the driver; after the stop
    // bit wait half a bit for a queued start. Limitation: the
    // count assumes eight data bits, one stop bit, no parity
    always_comb begin
        at_next   = at_reg;
        tick_next = tick_reg;
        bit_next  = bit_reg;
        case (at_reg)
            AT_IDLE: begin
                tick_next = '0;
                bit_next  = '0;
                if (!s_txd) begin
                    at_next = AT_BITS;
                end
            end
            AT_BITS: begin
                tick_next = tick_step(tick_reg, bt.tick, bit_end);
                if (bit_end) begin
                    bit_next = bit_reg + 1'b1;
                end
                if (frame_end) begin
                    bit_next = '0;
                    if (s_txd) begin
                        at_next = AT_STOP;
                    end
                end
            end
            AT_STOP: begin
                tick_next = tick_step(tick_reg, bt.tick, bit_end);
                if (!s_txd) begin
                    at_next   = AT_BITS;
                    tick_next = '0;
                end else if (guard_end) begin
                    at_next = AT_IDLE;
                end
            end
            default: begin
                at_next   = AT_IDLE;
                tick_next = '0;
                bit_next  = '0;
            end
        endcase
    end

    // Frame tracker state
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            at_reg   <= AT_IDLE;
            tick_reg <= '0;
            bit_reg  <= '0;
        end else begin
            at_reg   <= at_next;
            tick_reg <= tick_next;
            bit_reg  <= bit_next;
        end
    end

    // ************************************************************
    // Driver enable and receive path
    // ************************************************************
    logic   drv_en_next;
    logic   drv_en_reg;
    logic   rx_en_next;
    logic   rx_en_reg;
    logic   tx_reg;
    logic   rxd_reg;
    logic   line_rx;
    logic   loop_on;

    // Driver on only while this node sends; off by default so
    // the node never fights another talker
    assign drv_en_next = (drv_src == DRV_AUTO) ? (at_reg != AT_IDLE)
                       : (drv_src == DRV_RTS)  ? s_rts
                       : 1'b0;

    // Receiver cut while driving only in no-echo mode
    assign rx_en_next = !(s_no_echo && drv_en_next);

    // Loopback closes transmit onto receive while driving, both polarities set
    assign loop_on = s_loop_pos && s_loop_neg;
    assign line_rx = (loop_on && drv_en_reg) ? tx_reg
                   : (s_rx_pos && !s_rx_neg);

    // Line outputs from flip-flops
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            drv_en_reg <= 1'b0;
            rx_en_reg  <= 1'b1;
            tx_reg     <= `TX_IDLE_LEVEL;
            rxd_reg    <= `TX_IDLE_LEVEL;
        end else begin
            drv_en_reg <= drv_en_next;
            rx_en_reg  <= rx_en_next;
            tx_reg     <= s_txd;
            rxd_reg    <= rx_en_next ? line_rx : `TX_IDLE_LEVEL;
        end
    end

    // Output assignment
    assign tx_pos    = tx_reg;
    assign tx_neg    = !tx_reg;
    assign tx_drv_en = drv_en_reg;
    assign rx_en     = rx_en_reg;
    assign uart_rxd  = rxd_reg;
    assign line_busy = (at_reg != AT_IDLE);
endmodule

// ==== design/line_ctl_defs.svh ====
// Constants for the serial line control block
`ifndef LINE_CTL_DEFS_SVH
`define LINE_CTL_DEFS_SVH

// ****************************************************************
// Prescaler ratios
// ****************************************************************
`define QUARTER_RATIO   3'h4
`define BYPASS_RATIO    3'h1
`define PRESCALE_CNT_W  2
`define PRESCALE_LAST   2'h3

// ****************************************************************
// Serial frame timing, in baud ticks per bit
// ****************************************************************
`define TICKS_PER_BIT   5'h10
`define TICK_CNT_W      5
`define TICK_LAST       5'h0F
`define HALF_BIT_TICK   5'h07
// Frame of start, eight data and one stop bit, counted from zero
`define BIT_CNT_W       4
`define FRAME_LAST_BIT  4'h9

// ****************************************************************
// Reset values
// ****************************************************************
`define TX_IDLE_LEVEL   1'b1
// Synchroniser idle levels; only the negative receive line rests low
`define SYNC_W          11
`define SYNC_RESET      11'h7FE

`endif

// ==== design/line_ctl_pkg.sv ====
// Package with the types shared by the serial line control files
package line_ctl_pkg;

    // Driver enable source
    typedef enum logic [1:0] {
        DRV_OFF,
        DRV_AUTO,
        DRV_RTS,
        DRV_BAD
    } drv_src_t;

    // Prescale selection
    typedef enum logic [1:0] {
        CLK_NONE,
        CLK_QUARTER,
        CLK_BYPASS,
        CLK_INVALID
    } clk_sel_t;

endpackage

// ==== design/baud_tick_if.sv ====
// Interface carrying the baud tick from the prescaler to the control
`timescale 1ns/100ps
interface baud_tick_if;
    logic   tick;
    logic   sel_ok;

    modport source (output tick, output sel_ok);
    modport sink   (input  tick, input  sel_ok);
endinterface

// ==== design/baud_prescaler.sv ====
// Baud reference prescaler, divide by 4 or by 1
`timescale 1ns/100ps
`include "line_ctl_defs.svh"
module baud_prescaler (
    // Clock and reset
    input  wire logic               ref_clk,
    input  wire logic               rst,
    // Mode selection
    input  wire line_ctl_pkg::clk_sel_t sel,
    // Tick towards the control
    baud_tick_if.source             bt
);
    import line_ctl_pkg::*;

    logic [`PRESCALE_CNT_W-1:0] cnt_reg;
    logic [`PRESCALE_CNT_W-1:0] cnt_next;
    logic                       wrap;

    // Counter wraps every fourth clock in quarter mode
    assign wrap     = (cnt_reg == `PRESCALE_LAST);
    assign cnt_next = wrap ? '0 : cnt_reg + 1'b1;

    // Tick: every clock when bypassed, every fourth when quartered
    // Invalid or empty selection gives no tick at all, so the
    // UART stalls rather than runs at a wrong rate
    assign bt.tick   = (sel == CLK_BYPASS)  ? 1'b1 :
                       (sel == CLK_QUARTER) ? wrap : 1'b0;
    assign bt.sel_ok = (sel == CLK_BYPASS) || (sel == CLK_QUARTER);

    // Prescale counter
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            cnt_reg <= '0;
        end else begin
            cnt_reg <= cnt_next;
        end
    end
endmodule

// ==== verif/line_ctl_props.sv ====
// Concurrent checks on the line control ports
`timescale 1ns/100ps
// ****************************************************************
// Port checker
// ****************************************************************
module line_ctl_props (
    // Clock and reset
    input wire logic ref_clk,
    input wire logic rst,
    // Switch settings
    input wire logic auto_driver_enable_setting,
    input wire logic rts_driven_enable_setting,
    input wire logic receive_suppress_setting,
    input wire logic prescale_bypass_setting,
    input wire logic prescale_quarter_setting,
    // Observed pins
    input wire logic uart_rts,
    input wire logic uart_rxd,
    input wire logic uart_baud_tick,
    input wire logic tx_drv_en,
    input wire logic rx_en,
    input wire logic clk_sel_bad,
    input wire logic line_busy
);
    // Mode decodes; four held samples cover the two-flop sync
    wire logic byp = prescale_bypass_setting & ~prescale_quarter_setting;
    wire logic qtr = prescale_quarter_setting & ~prescale_bypass_setting;
    wire logic both = prescale_quarter_setting & prescale_bypass_setting;
    wire logic auto_m = auto_driver_enable_setting &
                        ~rts_driven_enable_setting;
    wire logic rts_m = rts_driven_enable_setting & ~auto_driver_enable_setting;
    wire logic dual = auto_driver_enable_setting & rts_driven_enable_setting;
    wire logic mute = receive_suppress_setting;

    default clocking dc @(posedge ref_clk); endclocking
    default disable iff (rst);

    sequence qtr_tick_s; qtr[*4] ##0 uart_baud_tick; endsequence
    sequence auto_held_s; auto_m[*4]; endsequence

    bypass_tick_a:
        assert property (byp[*4] |-> uart_baud_tick)
        else $error("tick missing in bypass mode");
    quarter_gap_a:
        assert property (qtr_tick_s |=> !uart_baud_tick[*2])
        else $error("quarter mode tick too early");
    both_sel_a:
        assert property (both[*4] |-> !uart_baud_tick && clk_sel_bad)
        else $error("tick or flag wrong with both prescale set");
    rts_follow_a:
        assert property ((rts_m && uart_rts)[*4] |-> tx_drv_en)
        else $error("driver not on with request high");
    rts_off_a:
        assert property ((rts_m && !uart_rts)[*4] |-> !tx_drv_en)
        else $error("driver on with request low");
    dual_mode_a:
        assert property (dual[*4] |-> !tx_drv_en)
        else $error("driver on with both enable modes");
    mute_rx_a:
        assert property (mute[*4] |-> rx_en != tx_drv_en)
        else $error("receiver enable wrong in no-echo mode");
    echo_rx_a:
        assert property ((!mute)[*4] |-> rx_en)
        else $error("receiver off with echo allowed");
    mute_data_a:
        assert property (!rx_en |-> uart_rxd)
        else $error("receive data not idle while muted");
    auto_start_a:
        assert property (auto_held_s ##0 $rose(line_busy) |=> tx_drv_en)
        else $error("driver not on after frame start");
    auto_release_a:
        assert property (auto_held_s ##0 $fell(line_busy) |=> !tx_drv_en)
        else $error("driver not released after frame");
endmodule

bind line_ctl line_ctl_props props (
    .ref_clk                    (ref_clk),
    .rst                        (rst),
    .auto_driver_enable_setting (auto_driver_enable_setting),
    .rts_driven_enable_setting  (rts_driven_enable_setting),
    .receive_suppress_setting   (receive_suppress_setting),
    .prescale_bypass_setting    (prescale_bypass_setting),
    .prescale_quarter_setting   (prescale_quarter_setting),
    .uart_rts                   (uart_rts),
    .uart_rxd                   (uart_rxd),
    .uart_baud_tick             (uart_baud_tick),
    .tx_drv_en                  (tx_drv_en),
    .rx_en                      (rx_en),
    .clk_sel_bad                (clk_sel_bad),
    .line_busy                  (line_busy)
);

// ==== verif/rs485_peer.sv ====
// Model of a multi-drop peer on the shared two-wire bus
`timescale 1ns/100ps
// ****************************************************************
// Bus peer
// ****************************************************************
module rs485_peer (
    // Device driver side
    input  wire logic tx_pos,
    input  wire logic tx_neg,
    input  wire logic tx_drv_en,
    // Peer transmit request from the bench
    input  wire logic peer_talk,
    input  wire logic peer_bit,
    // High for two-wire wiring, low for separate pairs
    input  wire logic two_wire,
    // Receiver pair of the device
    output logic      rx_pos,
    output logic      rx_neg
);
    // Peer stays tri-stated while the device drives
    wire logic peer_on = peer_talk & ~tx_drv_en;
    // Separate pairs keep our transmit off our receive pair, so
    // only the internal loopback can return it then
    wire logic mirror = tx_drv_en & two_wire;
    // Bias resistors pull a released bus to an idle mark
    assign rx_pos = mirror ? tx_pos : (peer_on ? peer_bit : 1'b1);
    assign rx_neg = mirror ? tx_neg : (peer_on ? ~peer_bit : 1'b0);
endmodule

// ==== verif/testbench.sv ====
// Self-checking bench for the serial line control block
`timescale 1ns/100ps
`include "line_ctl_defs.svh"
// ****************************************************************
// Bench top
// ****************************************************************
module testbench;
    logic ref_clk, rst, auto_set, rts_set, mute_set, byp_set, qtr_set;
    logic loop_set, uart_txd, uart_rts, peer_talk, peer_bit, md;
    logic uart_rxd, tick, tx_pos, tx_neg, drv_en, rx_pos, rx_neg;
    logic rx_en, sel_bad, busy, two_wire;
    logic [7:0] d, got;
    logic [7:0] q[$];
    integer seed, error_cnt, checks, n;

    line_ctl dut (.ref_clk(ref_clk), .rst(rst),
        .auto_driver_enable_setting(auto_set),
        .rts_driven_enable_setting(rts_set),
        .receive_suppress_setting(mute_set),
        .prescale_bypass_setting(byp_set),
        .prescale_quarter_setting(qtr_set),
        .loop_pos_setting(loop_set), .loop_neg_setting(loop_set),
        .uart_txd(uart_txd), .uart_rts(uart_rts), .uart_rxd(uart_rxd),
        .uart_baud_tick(tick), .tx_pos(tx_pos), .tx_neg(tx_neg),
        .tx_drv_en(drv_en), .rx_pos(rx_pos), .rx_neg(rx_neg),
        .rx_en(rx_en), .clk_sel_bad(sel_bad), .line_busy(busy));
    rs485_peer peer (.tx_pos(tx_pos), .tx_neg(tx_neg), .tx_drv_en(drv_en),
        .peer_talk(peer_talk), .peer_bit(peer_bit), .two_wire(two_wire),
        .rx_pos(rx_pos), .rx_neg(rx_neg));

    // 100 MHz reference clock
    initial begin
        ref_clk = 1'b0;
        forever #5 ref_clk = ~ref_clk;
    end

    task automatic report_and_stop;
        if (error_cnt == 0 && checks > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask

    task automatic chk(input string nm, input logic [7:0] e, g);
        checks++;
        if (g !== e) begin
            error_cnt++;
            $display("Error %s expected %h seen %h", nm, e, g);
        end
    endtask

    // Order auto, rts, mute, bypass, quarter, loop; waits out the sync
    task automatic cfg(input logic [5:0] s);
        @(negedge ref_clk);
        {auto_set, rts_set, mute_set, byp_set, qtr_set, loop_set} = s;
        repeat (6) @(negedge ref_clk);
    endtask

    // One 8N1 frame, 16 clocks a bit in bypass; samples late in each bit
    // because the echo path through the bus costs about six clocks
    task automatic frame(input logic [7:0] v, input logic from_peer);
        logic [9:0] b;
        b = {1'b1, v, 1'b0};
        for (int i = 0; i < 10; i++) begin
            @(negedge ref_clk);
            if (from_peer)
                peer_bit = b[i];
            else
                uart_txd = b[i];
            repeat (12) @(negedge ref_clk);
            if (i > 0 && i < 9)
                got[i-1] = uart_rxd;
            if (i == 9)
                md = drv_en;
            repeat (3) @(negedge ref_clk);
        end
    endtask

    // Bounded wait for the automatic driver release
    task automatic wait_release;
        for (int k = 0; drv_en !== 1'b0; k++) begin
            if (k == 100) begin
                error_cnt++;
                report_and_stop();
            end
            @(negedge ref_clk);
        end
    endtask

    initial begin
        seed = 32'h7b3f;
        {error_cnt, checks} = 0;
        {auto_set, rts_set, mute_set, byp_set, qtr_set, loop_set} = 0;
        {uart_txd, uart_rts, peer_talk, peer_bit, rst} = 5'h13;
        two_wire = 1'b1;
        repeat (10) @(negedge ref_clk);
        rst = 1'b0;
        // Prescale table: none, quarter, bypass, both
        for (int m = 0; m < 4; m++) begin
            cfg(6'(m) << 1);
            n = 0;
            repeat (64) begin
                @(negedge ref_clk);
                n += tick;
            end
            d = 8'((m == 2) ? 64 / `BYPASS_RATIO :
                   (m == 1) ? 64 / `QUARTER_RATIO : 0);
            chk("ticks", d, 8'(n));
            chk("sel_bad", (m == 0 || m == 3), sel_bad);
        end
        // Request-driven enable with the receiver muted
        cfg(6'h1c);
        uart_rts = 1'b1;
        repeat (4) @(negedge ref_clk);
        chk("drv_on", 1, drv_en);
        chk("rx_off", 0, rx_en);
        uart_rts = 1'b0;
        repeat (4) @(negedge ref_clk);
        chk("drv_off", 0, drv_en);
        // Both enable sources at once must leave the bus alone
        cfg(6'h34);
        uart_rts = 1'b1;
        repeat (4) @(negedge ref_clk);
        chk("drv_dual", 0, drv_en);
        uart_rts = 1'b0;
        // Peer talks while our driver is off, then auto modes, then loop
        for (int s = 0; s < 4; s++) begin
            cfg(s == 0 ? 6'h14 : s == 1 ? 6'h24 : s == 2 ? 6'h2c : 6'h15);
            uart_rts = (s == 3);
            two_wire = (s != 3);
            peer_talk = (s == 0);
            d = 8'($random(seed));
            d[3] = 1'b0;
            q.push_back(s == 2 ? 8'hff : d);
            frame(d, s == 0);
            peer_talk = 1'b0;
            chk("rx_data", q.pop_front(), got);
            if (s == 1 || s == 2) begin
                chk("drv_stop", 1, md);
                wait_release();
                chk("busy_end", 0, busy);
            end
        end
        report_and_stop();
    end
endmodule
